// ===== apr_pkg.sv
package apr_pkg;
   // ----------------------------------------
   // widths and timing
   // ----------------------------------------
   localparam int RES_BITS      = 12;
   localparam int BUS_BITS      = 16;
   localparam int CLK_PERIOD_PS = 10000;
   localparam int CONV_TIME_PS  = 2700000;
   // longest time rounds down
   localparam int CONV_CYCLES   = CONV_TIME_PS / CLK_PERIOD_PS;
   localparam int CNT_BITS      = 9;
   localparam logic [RES_BITS-1:0] RESULT_RESET = 12'h000;
   // host request kinds
   typedef enum logic [1:0] {
      APR_REQ_START_LOW,
      APR_REQ_HIGH,
      APR_REQ_NONE
   } apr_req_type;
endpackage

// ===== apr_if.sv
`timescale 1ns/1ps
interface apr_if;
   logic        cs_n;
   logic        rd_n;
   logic        byte_select_high;
   logic        busy_n;
   logic [15:0] data_out;
   logic [15:0] data_oe;
   modport dev  (input cs_n, input rd_n, input byte_select_high, output busy_n, output data_out, output data_oe);
   modport host (output cs_n, output rd_n, output byte_select_high, input busy_n, input data_out, input data_oe);
endinterface

// ===== apr_device.sv
`timescale 1ns/1ps
module apr_device
   import apr_pkg::*;
#(
   parameter int CONV_CYC = CONV_CYCLES
) (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                rst_n,
   // host side link
   apr_if.dev                       bus,
   // user side: sampled analog value
   input  wire logic [RES_BITS-1:0] sample_value,
   input  wire logic                two_byte_mode,
   output logic                     conv_done
);
   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic [2:0] sync1;
   logic [2:0] sync2;
   logic [2:0] next_sync1;
   logic       cs_s, rd_s, hb_s;
   always_comb begin
      next_sync1 = {bus.cs_n, bus.rd_n, bus.byte_select_high};
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1 <= 3'h7;
         sync2 <= 3'h7;
      end else begin
         sync1 <= next_sync1;
         sync2 <= sync1;
      end
   end
   assign {cs_s, rd_s, hb_s} = sync2;

   // ----------------------------------------
   // conversion engine
   // ----------------------------------------
   logic [CNT_BITS-1:0] cnt, next_cnt;
   logic                busy, next_busy;
   logic [RES_BITS-1:0] result, next_result;
   logic                start_req, req_prev, next_req_prev;
   logic                done, next_done;
   assign start_req = !cs_s && !rd_s && !hb_s;
   always_comb begin
      next_cnt      = cnt;
      next_busy     = busy;
      next_result   = result;
      next_done     = 1'b0;
      next_req_prev = start_req;
      if (busy) begin
         // requests while busy are dropped, not queued
         if (cnt == CNT_BITS'(CONV_CYC - 1)) begin
            next_busy   = 1'b0;
            next_result = sample_value;
            next_done   = 1'b1;
         end else begin
            next_cnt = cnt + CNT_BITS'(1);
         end
      end else if (start_req && !req_prev) begin
         next_busy = 1'b1;
         next_cnt  = '0;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt      <= '0;
         busy     <= 1'b0;
         result   <= RESULT_RESET;
         done     <= 1'b0;
         req_prev <= 1'b0;
      end else begin
         cnt      <= next_cnt;
         busy     <= next_busy;
         result   <= next_result;
         done     <= next_done;
         req_prev <= next_req_prev;
      end
   end

   // ----------------------------------------
   // output lanes
   // ----------------------------------------
   logic [BUS_BITS-1:0] dout, next_dout;
   logic                oe, next_oe;
   always_comb begin
      // lanes load on the edge that ends busy, so a waiting read never sees stale data
      next_oe   = !cs_s && !rd_s;
      next_dout = '0;
      next_dout[11:8] = next_result[11:8];
      if (two_byte_mode && hb_s) begin
         next_dout[3:0] = next_result[11:8];
      end else if (two_byte_mode) begin
         next_dout[7:0] = next_result[7:0];
      end else begin
         // previous result shown until the update lands
         next_dout[11:0] = next_result;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dout <= '0;
         oe   <= 1'b0;
      end else begin
         dout <= next_dout;
         oe   <= next_oe;
      end
   end
   assign bus.data_out = dout;
   assign bus.data_oe  = {BUS_BITS{oe}};
   assign bus.busy_n   = !busy;
   assign conv_done    = done;
endmodule

// ===== apr_host.sv
`timescale 1ns/1ps
module apr_host
   import apr_pkg::*;
#(
   parameter int CONV_CYC = CONV_CYCLES
) (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                rst_n,
   // device link
   apr_if.host                      bus,
   // user side
   input  wire logic                go,
   input  wire logic                wait_mode,
   input  wire logic                two_byte,
   output logic                     ready,
   output logic                     valid,
   output logic [RES_BITS-1:0]      data
);
   typedef enum {S_IDLE, S_RD, S_GAP, S_WAIT} apr_st_type;
   apr_st_type          st, next_st;
   logic [1:0]          idx, next_idx;
   logic [CNT_BITS+1:0] cnt, next_cnt;
   logic                cs, next_cs, hb, next_hb, vld, next_vld;
   logic [RES_BITS-1:0] dat, next_dat;
   logic [1:0]          bsy_s;
   localparam int RD_CYC = 8;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) bsy_s <= 2'h3;
      else bsy_s <= {bsy_s[0], bus.busy_n};
   end
   always_comb begin
      next_st = st; next_idx = idx; next_cnt = cnt; next_cs = cs;
      next_hb = hb; next_vld = 1'b0; next_dat = dat;
      case (st)
         S_IDLE: if (go) begin
            next_st = S_RD; next_idx = '0; next_cnt = '0;
            next_cs = 1'b1; next_hb = 1'b0;
         end
         S_RD: begin
            next_cnt = cnt + (CNT_BITS+2)'(1);
            // in wait mode, hold the first read cycle while busy reads low
            if (cnt >= (CNT_BITS+2)'(RD_CYC) && !(wait_mode && idx == 2'h0 && !bsy_s[1])) begin
               next_cs = 1'b0; next_cnt = '0;
               if (hb) next_dat[11:8] = bus.data_out[3:0];
               else if (two_byte) next_dat[7:0] = bus.data_out[7:0];
               else next_dat = bus.data_out[11:0];
               if (!two_byte && wait_mode) begin
                  next_st = S_IDLE; next_vld = 1'b1;
               end else if (!two_byte) begin
                  // deferred read: wait, then fetch fresh data
                  next_st = (idx == 2'h0) ? S_GAP : S_IDLE;
                  next_vld = idx != 2'h0; next_idx = idx + 2'h1;
               end else if (wait_mode) begin
                  next_st = (idx == 2'h0) ? S_WAIT : S_IDLE;
                  next_vld = idx != 2'h0; next_hb = 1'b1; next_idx = idx + 2'h1;
               end else begin
                  // start, gap, then high and low byte of the new result
                  next_idx = idx + 2'h1;
                  next_hb = idx == 2'h0;
                  next_st = (idx == 2'h2) ? S_IDLE : (idx == 2'h0 ? S_GAP : S_WAIT);
                  next_vld = idx == 2'h2;
               end
            end
         end
         S_WAIT: begin
            next_cnt = cnt + (CNT_BITS+2)'(1);
            if (cnt >= (CNT_BITS+2)'(2)) begin
               next_st = S_RD; next_cs = 1'b1; next_cnt = '0;
            end
         end
         S_GAP: begin
            next_cnt = cnt + (CNT_BITS+2)'(1);
            if (cnt >= (CNT_BITS+2)'(CONV_CYC + 8)) begin
               next_st = S_RD; next_cs = 1'b1; next_cnt = '0;
            end
         end
         default: next_st = S_IDLE;
      endcase
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= S_IDLE; idx <= '0; cnt <= '0; cs <= 1'b0;
         hb <= 1'b0; vld <= 1'b0; dat <= '0;
      end else begin
         st <= next_st; idx <= next_idx; cnt <= next_cnt; cs <= next_cs;
         hb <= next_hb; vld <= next_vld; dat <= next_dat;
      end
   end
   assign bus.cs_n             = !cs;
   assign bus.rd_n             = !cs;
   assign bus.byte_select_high = hb;
   assign ready = st == S_IDLE;
   assign valid = vld;
   assign data  = dat;
endmodule

// ===== apr_checker_assertions.sv
`timescale 1ns/1ps
module apr_checker
   import apr_pkg::*;
#(
   parameter int CONV_CYC = CONV_CYCLES
) (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // link signals
   input wire logic        cs_n,
   input wire logic        rd_n,
   input wire logic        byte_select_high,
   input wire logic        busy_n,
   input wire logic [15:0] data_out,
   input wire logic [15:0] data_oe
);
   // ----------------------------------------
   // busy length counter
   // ----------------------------------------
   logic [CNT_BITS-1:0] busy_cnt;
   logic [CNT_BITS-1:0] next_busy_cnt;
   always_comb begin
      next_busy_cnt = busy_n ? '0 : busy_cnt + 1'b1;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_cnt <= '0;
      end else begin
         busy_cnt <= next_busy_cnt;
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_float_idle: assert property (cs_n [*4] |-> data_oe == 16'h0000)
      else $error("lanes driven while idle");
   a_drive_read: assert property ((!cs_n && !rd_n) [*4] |-> data_oe == 16'hffff)
      else $error("lanes not driven in read");
   a_high_nibble: assert property ((!cs_n && !rd_n && byte_select_high) [*5]
      |-> data_out[3:0] == data_out[11:8] && data_out[7:4] == 4'h0)
      else $error("high byte lanes wrong");
   a_upper_zero: assert property (data_oe[0] |-> data_out[15:12] == 4'h0)
      else $error("unused lanes not zero");
   a_start_busy: assert property ($rose(!cs_n && !rd_n && !byte_select_high) && busy_n
      |-> ##[3:5] !busy_n)
      else $error("start not taken");
   a_start_cause: assert property ($fell(busy_n) |-> $past(!cs_n && !rd_n && !byte_select_high, 3))
      else $error("busy without start");
   a_busy_hold: assert property ($fell(busy_n) |-> !busy_n [*8])
      else $error("busy dropped early");
   a_conv_bound: assert property (!busy_n |-> busy_cnt <= CONV_CYC + 1)
      else $error("conversion too long");
   a_conv_len: assert property ($rose(busy_n) |-> $past(busy_cnt) + 1 >= CONV_CYC)
      else $error("conversion too short");
   a_done_drives: assert property ($rose(busy_n) && $past(!cs_n && !rd_n, 3)
      |-> data_oe == 16'hffff)
      else $error("result not driven at end");
   c_start: cover property ($fell(busy_n));
   c_high: cover property (!cs_n && !rd_n && byte_select_high);
   c_wait_end: cover property ($rose(busy_n) && !cs_n);
endmodule

// ===== test_adc_parallel_read_port.sv
`timescale 1ns/1ps
module test_adc_parallel_read_port;
   import apr_pkg::*;
   localparam int CC = 20;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [RES_BITS-1:0] sample_value = 12'h000;
   logic two_byte_mode = 1'b0;
   logic conv_done;
   logic go = 1'b0;
   logic wait_mode = 1'b0;
   logic two_byte = 1'b0;
   logic ready;
   logic valid;
   logic [RES_BITS-1:0] data;
   int fails = 0;
   int compares = 0;
   int cyc = 0;
   int convs = 0;
   logic [RES_BITS-1:0] last = RESULT_RESET;
   always #5 clk = ~clk;
   // conversions finished, one per done pulse
   always @(posedge clk) begin
      if (conv_done === 1'b1) begin
         convs++;
      end
   end
   apr_if i_apr_if ();
   apr_device #(.CONV_CYC(CC)) i_apr_device (.clk(clk), .rst_n(rst_n), .bus(i_apr_if.dev),
      .sample_value(sample_value), .two_byte_mode(two_byte_mode), .conv_done(conv_done));
   apr_host #(.CONV_CYC(CC)) i_apr_host (.clk(clk), .rst_n(rst_n), .bus(i_apr_if.host), .go(go),
      .wait_mode(wait_mode), .two_byte(two_byte), .ready(ready), .valid(valid), .data(data));
   apr_checker #(.CONV_CYC(CC)) i_apr_checker (.clk(clk), .rst_n(rst_n), .cs_n(i_apr_if.cs_n),
      .rd_n(i_apr_if.rd_n), .byte_select_high(i_apr_if.byte_select_high), .busy_n(i_apr_if.busy_n),
      .data_out(i_apr_if.data_out), .data_oe(i_apr_if.data_oe));
   // ----------------------------------------
   // closing report
   // ----------------------------------------
   task automatic summarize();
      $display("fails=%0d compares=%0d", fails, compares);
      if (fails == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // hang guard: all reads fit well inside this
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         summarize();
      end
   end
   // ----------------------------------------
   // one host transfer, result compared at valid
   // ----------------------------------------
   task automatic xfer(input logic w, input logic t, input logic [11:0] s, input logic [11:0] exp);
      int n;
      int c0;
      int exp_conv;
      n = 0;
      c0 = convs;
      exp_conv = w ? 1 : 2;
      while (ready !== 1'b1 && n < 500) begin
         @(posedge clk);
         n++;
      end
      sample_value <= s;
      wait_mode <= w;
      two_byte <= t;
      two_byte_mode <= t;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      n = 0;
      @(negedge clk);
      // the starting read shows the previous result on lanes 11:0
      while (i_apr_if.data_oe[0] !== 1'b1 && n < 500) begin
         @(negedge clk);
         n++;
      end
      compares++;
      if (i_apr_if.data_out[11:0] !== last) begin
         fails++;
         $display("unexpected first read at %0t: got %h expected %h", $time, i_apr_if.data_out[11:0], last);
      end
      n = 0;
      while (valid !== 1'b1 && n < 500) begin
         @(negedge clk);
         n++;
      end
      compares++;
      if (valid !== 1'b1 || data !== exp) begin
         fails++;
         $display("unexpected data at %0t: got %h expected %h", $time, data, exp);
      end
      // let any conversion started by the last read finish before counting
      repeat (CC + 30) @(posedge clk);
      // wait-read starts once, deferred-read starts at first and last read
      compares++;
      if (convs - c0 != exp_conv) begin
         fails++;
         $display("unexpected conversions at %0t: got %h expected %h", $time, convs - c0, exp_conv);
      end
      last = s;
      $display("test w=%0d t=%0d done", w, t);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      xfer(1'b0, 1'b0, 12'h5a3, 12'h5a3);
      xfer(1'b1, 1'b0, 12'h6b4, 12'h6b4);
      xfer(1'b1, 1'b1, 12'ha5c, 12'ha5c);
      xfer(1'b0, 1'b0, 12'h123, 12'h123);
      xfer(1'b0, 1'b0, 12'h3c7, 12'h3c7);
      xfer(1'b0, 1'b1, 12'hb81, 12'hb81);
      xfer(1'b0, 1'b1, 12'h4e2, 12'h4e2);
      summarize();
   end
endmodule
